// ==== hw/irq_params.svh ====
// constants of the interrupt request and acknowledge block
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH
`define IRQ_NSRC          8
`define IRQ_ACK_ADDR      20'h00000
`define IRQ_SP_RESET      16'h0000
// register offsets of the plain register port
`define IRQ_OFS_VECTOR    8'h00
`define IRQ_OFS_PEND      8'h04
`define IRQ_OFS_ENABLE    8'h08
`define IRQ_OFS_LEVEL_LO  8'h0C
`define IRQ_OFS_LEVEL_HI  8'h10
`define IRQ_OFS_POLARITY  8'h14
`define IRQ_OFS_FILTER    8'h18
`define IRQ_OFS_SP        8'h1C
`define IRQ_OFS_MASK      8'h20
`define IRQ_OFS_STATUS    8'h24
`define IRQ_FILT_SAMPLES  3
`endif

// ==== hw/irq_pkg.sv ====
// types of the interrupt request and acknowledge block
`include "irq_params.svh"
package irq_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } irq_bus_req_t;
  typedef struct packed {
    logic       valid;
    logic [2:0] number;
    logic [2:0] level;
  } irq_vec_t;
endpackage

// ==== hw/irq_request_ack_logic.sv ====
// maskable interrupt request flags with acknowledge and vector read
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// RULE_01: acknowledge read returns interrupt number and level
// RULE_02: acknowledge clears flag of acknowledged source
// RULE_03: program vector read clears highest priority flag
// RULE_04: stack pointer resets to zero
// RULE_05: source change may set flag; a polarity change alone does not
// RULE_06: software clears flag after source change
// RULE_07: pin levels held at least minimum width
// RULE_08: filtered pin levels held three filter clocks
// RULE_09: flag stays set until ack, vector read, write, reset
module irq_request_ack_logic (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 srst_i,
  // register port
  input  wire irq_pkg::irq_bus_req_t bus_i,
  output logic [15:0]               rdata_o,
  // interrupt sequence
  input  wire logic                 ack_i,
  output irq_pkg::irq_vec_t         vec_o,
  output logic                      irq_req_o,
  // sources: external and key pins, filter tick
  input  wire logic [3:0]           ext_irq_input_i,
  input  wire logic                 key_input_0_i,
  input  wire logic                 key_input_1_i,
  input  wire logic                 key_input_2_i,
  input  wire logic                 key_input_3_i,
  input  wire logic                 filt_tick_i,
  // status and summary interrupt
  output logic [15:0]               stack_pointer_o,
  output logic                      int_o
);
  import irq_pkg::*;
  localparam int N = `IRQ_NSRC;

  // ==========================================
  // pin synchronisers and filter
  logic [N-1:0] s1_reg;
  logic [N-1:0] s2_reg;
  logic [N-1:0] pins;
  assign pins = {key_input_3_i, key_input_2_i, key_input_1_i, key_input_0_i, ext_irq_input_i};
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
    end
  end

  logic [N-1:0] filter_reg;
  logic [N-1:0] polarity_reg;
  logic [1:0]   fh_reg [N];
  logic [N-1:0] lvl_reg;
  logic [N-1:0] lvl_prev_reg;
  // filtered level follows pin after three agreeing ticks [RULE_08]
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lvl_reg <= '0;
      for (int i = 0; i < N; i++) begin
        fh_reg[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (!filter_reg[i]) begin
          lvl_reg[i] <= s2_reg[i];
          fh_reg[i]  <= 2'h0;
        end else if (filt_tick_i) begin
          if (s2_reg[i] == lvl_reg[i]) begin
            fh_reg[i] <= 2'h0;
          end else if (fh_reg[i] == 2'(`IRQ_FILT_SAMPLES - 1)) begin
            lvl_reg[i] <= s2_reg[i];
            fh_reg[i]  <= 2'h0;
          end else begin
            fh_reg[i] <= fh_reg[i] + 2'h1;
          end
        end
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lvl_prev_reg <= '0;
    end else begin
      lvl_prev_reg <= lvl_reg;
    end
  end
  logic [N-1:0] edge_evt;
  // active edge per polarity; a polarity change alone makes no edge [RULE_05]
  assign edge_evt = (lvl_reg & ~lvl_prev_reg & polarity_reg) | (~lvl_reg & lvl_prev_reg & ~polarity_reg);

  // ==========================================
  // configuration registers
  logic [N-1:0]   enable_reg;
  logic [2*N-1:0] level_lo_reg;
  logic [N-1:0]   level_hi_reg;
  logic [N-1:0]   mask_reg;
  logic [15:0]    sp_reg;
  logic           wr_cfg;
  assign wr_cfg = bus_i.wr;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      enable_reg   <= '0;
      level_lo_reg <= '0;
      level_hi_reg <= '0;
      polarity_reg <= '0;
      filter_reg   <= '0;
      mask_reg     <= '0;
    end else if (wr_cfg) begin
      case (bus_i.addr)
        `IRQ_OFS_ENABLE:   enable_reg   <= bus_i.wdata[N-1:0];
        `IRQ_OFS_LEVEL_LO: level_lo_reg <= bus_i.wdata;
        `IRQ_OFS_LEVEL_HI: level_hi_reg <= bus_i.wdata[N-1:0];
        `IRQ_OFS_POLARITY: polarity_reg <= bus_i.wdata[N-1:0];
        `IRQ_OFS_FILTER:   filter_reg   <= bus_i.wdata[N-1:0];
        `IRQ_OFS_MASK:     mask_reg     <= bus_i.wdata[N-1:0];
        default: ;
      endcase
    end
  end
  // stack pointer is zero until software loads it [RULE_04]
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sp_reg <= `IRQ_SP_RESET;
    end else if (wr_cfg && bus_i.addr == `IRQ_OFS_SP) begin
      sp_reg <= bus_i.wdata;
    end
  end
  assign stack_pointer_o = sp_reg;

  // ==========================================
  // priority selection
  function automatic logic [2:0] src_level(input logic [2*N-1:0] lo, input logic [N-1:0] hi, input int i);
    src_level = {hi[i], lo[2*i+1], lo[2*i]};
  endfunction
  logic [N-1:0] pend_reg;
  logic [N-1:0] cand;
  logic         win_valid;
  logic [2:0]   win_num;
  logic [2:0]   win_lvl;
  assign cand = pend_reg & enable_reg;
  always_comb begin
    win_valid = 1'b0;
    win_num   = 3'h0;
    win_lvl   = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (cand[i] && (!win_valid || src_level(level_lo_reg, level_hi_reg, i) > win_lvl)) begin
        win_valid = 1'b1;
        win_num   = 3'(i);
        win_lvl   = src_level(level_lo_reg, level_hi_reg, i);
      end
    end
  end
  assign irq_req_o = win_valid && (win_lvl != 3'h0);

  // ==========================================
  // pending flags
  logic vec_rd;
  logic take;
  logic [N-1:0] clr_ack;
  logic [N-1:0] sw_wr;
  assign vec_rd = bus_i.rd && bus_i.addr == `IRQ_OFS_VECTOR;
  assign take   = (ack_i || vec_rd) && win_valid;
  // ack and program vector read both clear the winner [RULE_02] [RULE_03]
  assign clr_ack = take ? (N'(1) << win_num) : '0;
  assign sw_wr   = (wr_cfg && bus_i.addr == `IRQ_OFS_PEND) ? ~bus_i.wdata[N-1:0] : '0;
  // new event wins over any clear; flag holds otherwise [RULE_09] [RULE_06]
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~clr_ack & ~sw_wr) | edge_evt;
    end
  end
  // vector captured during the acknowledge read [RULE_01]
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      vec_o <= '0;
    end else if (ack_i || vec_rd) begin
      vec_o <= '{valid: win_valid, number: win_num, level: win_lvl};
    end else begin
      vec_o.valid <= 1'b0;
    end
  end

  // ==========================================
  // summary status, mask and read data
  logic [N-1:0] status_reg;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~((wr_cfg && bus_i.addr == `IRQ_OFS_STATUS) ? bus_i.wdata[N-1:0] : '0))
                    | edge_evt;
    end
  end
  assign int_o = |(status_reg & mask_reg);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        `IRQ_OFS_VECTOR:   rdata_o <= {9'h000, win_valid, win_lvl, win_num};
        `IRQ_OFS_PEND:     rdata_o <= {8'h00, pend_reg};
        `IRQ_OFS_ENABLE:   rdata_o <= {8'h00, enable_reg};
        `IRQ_OFS_LEVEL_LO: rdata_o <= level_lo_reg;
        `IRQ_OFS_LEVEL_HI: rdata_o <= {8'h00, level_hi_reg};
        `IRQ_OFS_POLARITY: rdata_o <= {8'h00, polarity_reg};
        `IRQ_OFS_FILTER:   rdata_o <= {8'h00, filter_reg};
        `IRQ_OFS_SP:       rdata_o <= sp_reg;
        `IRQ_OFS_MASK:     rdata_o <= {8'h00, mask_reg};
        `IRQ_OFS_STATUS:   rdata_o <= {8'h00, status_reg};
        default:           rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ==========================================
  // assertions
  AST_ACK_CLEARS: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_02]
    (ack_i && win_valid && !edge_evt[win_num]) |=> !pend_reg[$past(win_num)])
    else $error("acknowledged flag not cleared");
  AST_VEC_RD_CLEARS: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_03]
    (vec_rd && win_valid && !edge_evt[win_num]) |=> !pend_reg[$past(win_num)])
    else $error("vector read did not clear winner");
  AST_VEC_NUMBER: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_01]
    (ack_i && win_valid) |=> (vec_o.valid && vec_o.number == $past(win_num) && vec_o.level == $past(win_lvl)))
    else $error("vector does not match winner");
  AST_SP_RESET: assert property (@(posedge mclk_i) // [RULE_04]
    (!srst_i && $past(srst_i)) |-> sp_reg == `IRQ_SP_RESET)
    else $error("stack pointer not zero after reset");
  AST_SP_HOLDS: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_04]
    !(wr_cfg && bus_i.addr == `IRQ_OFS_SP) |=> $stable(sp_reg))
    else $error("stack pointer moved without a load");
  AST_FLAG_HOLDS: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_09]
    (pend_reg[0] && !(take && win_num == 3'h0) && !sw_wr[0]) |=> pend_reg[0])
    else $error("flag dropped without a clear");
  AST_EVENT_SETS: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_05]
    (edge_evt != '0) |=> ((pend_reg & status_reg & $past(edge_evt)) == $past(edge_evt)))
    else $error("event did not set flag");
  AST_SW_CLEAR: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_06]
    (sw_wr[2] && !edge_evt[2]) |=> !pend_reg[2])
    else $error("software clear ignored");
  AST_FILTER: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_08]
    (filter_reg[0] && $changed(lvl_reg[0]) && $past(filter_reg[0])) |-> $past(filt_tick_i))
    else $error("filtered level moved without tick");
endmodule

// ==== testbench/irq_pin_src_model.sv ====
// pin-side source model: interrupt and key inputs plus filter tick
`timescale 1ns/1ps
module irq_pin_src_model #(
  parameter int MIN_W_CYC = 40,
  parameter int TICK_DIV  = 4
) (
  // clock
  input  wire logic  mclk_i,
  // pins and filter tick
  output logic [7:0] pins_o,
  output logic       filt_tick_o
);
  int cnt = 0;
  initial begin
    pins_o = '0;
    filt_tick_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    filt_tick_o <= (cnt == TICK_DIV - 1);
  end
  // one high pulse; each level held the longer of the plain minimum and three ticks
  task automatic pulse(input int idx);
    int hold;
    hold = (MIN_W_CYC > 3 * TICK_DIV) ? MIN_W_CYC : 3 * TICK_DIV;
    pins_o[idx] <= 1'b1;
    repeat (hold) @(posedge mclk_i);
    pins_o[idx] <= 1'b0;
    repeat (hold) @(posedge mclk_i);
  endtask
endmodule

// ==== testbench/irq_request_ack_logic_test.sv ====
// self-checking bench of the interrupt request and acknowledge block
`timescale 1ns/1ps
`include "irq_params.svh"
module irq_request_ack_logic_test;
  import irq_pkg::*;
  logic         mclk_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         ack_i  = 1'b0;
  irq_bus_req_t bus_i  = '0;
  logic [15:0]  rdata_o;
  logic [15:0]  stack_pointer_o;
  irq_vec_t     vec_o;
  logic         irq_req_o;
  logic         int_o;
  logic [7:0]   pins;
  logic         tick;
  int           failures  = 0;
  int           tests_run = 0;
  int           cyc       = 0;
  // ==========================================
  // clock, pin sources, design
  initial forever #12.5 mclk_i = ~mclk_i;
  irq_pin_src_model i_src (.mclk_i(mclk_i), .pins_o(pins), .filt_tick_o(tick));
  irq_request_ack_logic i_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o), .ack_i(ack_i), .vec_o(vec_o),
    .irq_req_o(irq_req_o), .ext_irq_input_i(pins[3:0]), .key_input_0_i(pins[4]), .key_input_1_i(pins[5]),
    .key_input_2_i(pins[6]), .key_input_3_i(pins[7]), .filt_tick_i(tick),
    .stack_pointer_o(stack_pointer_o), .int_o(int_o));
  // ==========================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk_i);
    bus_i <= '0;
    @(posedge mclk_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk_i);
    bus_i <= '0;
    #1 chk(rdata_o, exp);
    @(posedge mclk_i);
  endtask
  task automatic ack(input logic [15:0] exp);
    ack_i <= 1'b1;
    @(posedge mclk_i);
    ack_i <= 1'b0;
    #1 chk({9'h000, vec_o}, exp);
    @(posedge mclk_i);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    rchk(`IRQ_OFS_SP, `IRQ_SP_RESET);
    chk(stack_pointer_o, `IRQ_SP_RESET);
    wr(`IRQ_OFS_SP, 16'hA5C3);
    chk(stack_pointer_o, 16'hA5C3);
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    chk(stack_pointer_o, `IRQ_SP_RESET);
    rchk(8'hFC, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_ack;
    wr(`IRQ_OFS_POLARITY, 16'h00FF);
    wr(`IRQ_OFS_PEND, 16'h0000);
    rchk(`IRQ_OFS_PEND, 16'h0000);
    wr(`IRQ_OFS_ENABLE, 16'h00FF);
    wr(`IRQ_OFS_LEVEL_LO, 16'h3010);
    wr(`IRQ_OFS_LEVEL_HI, 16'h0004);
    chk(irq_req_o, 1'b0);
    i_src.pulse(2);
    i_src.pulse(6);
    rchk(`IRQ_OFS_PEND, 16'h0044);
    chk(irq_req_o, 1'b1);
    ack(16'h0055);
    rchk(`IRQ_OFS_PEND, 16'h0040);
    $display("acknowledge test done");
  endtask
  task automatic t_prog;
    wr(`IRQ_OFS_ENABLE, 16'h00FB);
    i_src.pulse(2);
    rchk(`IRQ_OFS_VECTOR, 16'h005E);
    rchk(`IRQ_OFS_PEND, 16'h0004);
    wr(`IRQ_OFS_PEND, 16'h0000);
    chk(irq_req_o, 1'b0);
    ack(16'h0000);
    $display("vector read test done");
  endtask
  task automatic t_irq;
    wr(`IRQ_OFS_STATUS, 16'h00FF);
    wr(`IRQ_OFS_MASK, 16'h0001);
    wr(`IRQ_OFS_FILTER, 16'h000F);
    chk(int_o, 1'b0);
    i_src.pulse(0);
    chk(int_o, 1'b1);
    rchk(`IRQ_OFS_STATUS, 16'h0001);
    wr(`IRQ_OFS_MASK, 16'h0000);
    chk(int_o, 1'b0);
    wr(`IRQ_OFS_STATUS, 16'h0001);
    wr(`IRQ_OFS_MASK, 16'h0001);
    chk(int_o, 1'b0);
    rchk(`IRQ_OFS_STATUS, 16'h0000);
    $display("interrupt test done");
  endtask
  // ==========================================
  // sequence and hang guard
  initial begin
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    t_reset;
    t_ack;
    t_prog;
    t_irq;
    results;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results;
    end
  end
endmodule
